// >>> msr_pkg.sv
// Shared constants, types and helpers for the MSI request, mask and pending block
`default_nettype none
package msr_pkg;
  localparam int NUM_FUNC = 4;
  localparam int FUNC_W   = 2;
  localparam int NUM_VEC  = 32;
  localparam int VEC_W    = 5;

  // Capability register offsets
  localparam logic [11:0] CTRL_OFS    = 12'h050;
  localparam logic [11:0] ADDR_LO_OFS = 12'h054;
  localparam logic [11:0] ADDR_HI_OFS = 12'h058;
  localparam logic [11:0] DATA_OFS    = 12'h05c;
  localparam logic [11:0] MASK_OFS    = 12'h060;
  localparam logic [11:0] PEND_OFS    = 12'h064;

  // Control word fields
  localparam int EN_BIT   = 16;
  localparam int MMC_LSB  = 17;
  localparam int MME_LSB  = 20;
  localparam int A64_BIT  = 23;
  localparam int PVM_BIT  = 24;
  localparam int NEXT_LSB = 8;
  localparam logic [7:0]  CAP_ID     = 8'h05;
  localparam logic [7:0]  NEXT_PTR   = 8'h00;
  localparam logic [2:0]  MMC_VAL    = 3'h5;
  localparam logic [2:0]  MME_RST    = 3'h0;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] PEND_RST   = 32'h0000_0000;
  localparam logic [63:0] ADDR_RST   = 64'h0;
  localparam logic [15:0] DATA_RST   = 16'h0000;

  // Result codes returned with the acknowledge
  localparam logic [1:0] ST_SENT    = 2'h0;
  localparam logic [1:0] ST_MASKED  = 2'h1;
  localparam logic [1:0] ST_DROPPED = 2'h2;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [FUNC_W-1:0] func;
    logic [11:0]       addr;
    logic [31:0]       wdata;
  } msr_cfg_req_t;

  typedef struct packed {
    logic              req;
    logic [FUNC_W-1:0] func;
    logic [VEC_W-1:0]  num;
  } msr_msi_req_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] data;
  } msr_mwr_t;

  // Vector lies within the enabled count of 2**mme
  function automatic logic vec_enabled(input logic [2:0] mme, input logic [VEC_W-1:0] num);
    logic [5:0] cnt;
    cnt = 6'h01 << mme;
    return {1'b0, num} < cnt;
  endfunction

  // Message data: low mme bits carry the vector number
  function automatic logic [31:0] msg_data(input logic [15:0] data, input logic [2:0] mme,
                                           input logic [VEC_W-1:0] num);
    logic [15:0] sel;
    sel = (16'h0001 << mme) - 16'h0001;
    return {16'h0000, (data & ~sel) | ({11'h000, num} & sel)};
  endfunction
endpackage
`default_nettype wire

// >>> msr_pend_pick.sv
// Picks the lowest function and vector with a pending, unmasked interrupt
`default_nettype none
module msr_pend_pick (
  input  wire logic [msr_pkg::NUM_FUNC*msr_pkg::NUM_VEC-1:0] cand_i,
  output logic                                               valid_o,
  output logic [msr_pkg::FUNC_W-1:0]                         func_o,
  output logic [msr_pkg::VEC_W-1:0]                          num_o
);
  always_comb begin
    valid_o = 1'b0;
    func_o  = '0;
    num_o   = '0;
    for (int i = msr_pkg::NUM_FUNC*msr_pkg::NUM_VEC-1; i >= 0; i--) begin
      if (cand_i[i]) begin
        valid_o = 1'b1;
        func_o  = msr_pkg::FUNC_W'(i / msr_pkg::NUM_VEC);
        num_o   = msr_pkg::VEC_W'(i % msr_pkg::NUM_VEC);
      end
    end
  end
endmodule
`default_nettype wire

// >>> msr_mwr_out.sv
// Holds one outgoing Memory Write message until the transaction side takes it
`default_nettype none
module msr_mwr_out (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              load_i,
  input  wire msr_pkg::msr_mwr_t msg_i,
  input  wire logic              ready_i,
  output logic                   valid_o,
  output msr_pkg::msr_mwr_t      msg_o
);
  logic              valid_reg;
  logic              valid_next;
  msr_pkg::msr_mwr_t msg_reg;
  msr_pkg::msr_mwr_t msg_next;

  always_comb begin
    valid_next = valid_reg;
    msg_next   = msg_reg;
    if (valid_reg && ready_i) begin
      valid_next = 1'b0;
    end
    if (load_i) begin
      valid_next = 1'b1;
      msg_next   = msg_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_reg <= 1'b0;
      msg_reg   <= '0;
    end else begin
      valid_reg <= valid_next;
      msg_reg   <= msg_next;
    end
  end

  assign valid_o = valid_reg;
  assign msg_o   = msg_reg;
endmodule
`default_nettype wire

// >>> msr_msi_ctrl.sv
// MSI generation with per-function, per-vector masking and pending bits
// Function
// - MSI enable is bit 16 at 0x050
// - Messages use programmed MSI address and data
// - Enabled vector count from Multiple Message Enable
// - Unmasked enabled vector: code 0, send write
// - MSI disabled: drop request, return code 2
// - One mask bit per function and vector
// - Masked request sets pending, sends nothing
// - Masked request still acknowledged with code 1
// - Pending bits readable per function
// - Unmask with pending set sends, clears pending
// - Pending bit clearable by write while masked
// - Pending cleared before unmask: nothing sent
`default_nettype none
module msr_msi_ctrl (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire msr_pkg::msr_cfg_req_t cfg_i,
  output logic [31:0]                cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  input  wire msr_pkg::msr_msi_req_t msi_i,
  output logic                       msi_ack_o,
  output logic [1:0]                 msi_status_o,
  output logic                       mwr_valid_o,
  output msr_pkg::msr_mwr_t          mwr_o,
  input  wire logic                  mwr_ready_i
);
  localparam int NF = msr_pkg::NUM_FUNC;
  localparam int NV = msr_pkg::NUM_VEC;

  typedef enum logic [1:0] {
    MSR_IDLE = 2'b01,
    MSR_ACK  = 2'b10
  } msr_state_t;

  // Configuration state
  logic        en_reg   [NF];
  logic        en_next  [NF];
  logic [2:0]  mme_reg  [NF];
  logic [2:0]  mme_next [NF];
  logic [63:0] addr_reg [NF];
  logic [63:0] addr_next[NF];
  logic [15:0] data_reg [NF];
  logic [15:0] data_next[NF];
  logic [31:0] mask_reg [NF];
  logic [31:0] mask_next[NF];
  logic [31:0] pend_reg [NF];
  logic [31:0] pend_next[NF];

  // Request handling state
  msr_state_t  state_reg;
  msr_state_t  state_next;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  logic                         take;
  logic                         flush;
  logic                         emit_busy;
  logic                         emit_load;
  msr_pkg::msr_mwr_t            emit_msg;
  logic [NF*NV-1:0]             cand;
  logic                         pick_valid;
  logic [msr_pkg::FUNC_W-1:0]   pick_func;
  logic [msr_pkg::VEC_W-1:0]    pick_num;
  logic                         req_en;
  logic                         req_vec_ok;
  logic                         req_masked;
  logic [63:0]                  req_addr;

  assign req_en     = en_reg[msi_i.func];
  assign req_vec_ok = msr_pkg::vec_enabled(mme_reg[msi_i.func], msi_i.num);
  assign req_masked = mask_reg[msi_i.func][msi_i.num];
  assign req_addr   = addr_reg[msi_i.func];

  // Held interrupts become candidates only once unmasked on an enabled function
  always_comb begin
    for (int f = 0; f < NF; f++) begin
      cand[f*NV +: NV] = pend_reg[f] & ~mask_reg[f] & {NV{en_reg[f]}};
    end
  end

  msr_pend_pick u_pick (
    .cand_i  (cand),
    .valid_o (pick_valid),
    .func_o  (pick_func),
    .num_o   (pick_num)
  );

  // Request handling: one request at a time, answered in the following cycle
  always_comb begin
    state_next  = state_reg;
    status_next = status_reg;
    emit_load   = 1'b0;
    emit_msg    = '0;
    take        = (state_reg == MSR_IDLE) && msi_i.req && !emit_busy;
    flush       = (state_reg == MSR_IDLE) && !take && pick_valid && !emit_busy;
    unique case (state_reg)
      MSR_IDLE: begin
        if (take) begin
          state_next = MSR_ACK;
          if (!req_en || !req_vec_ok) begin
            status_next = msr_pkg::ST_DROPPED;
          end else if (req_masked) begin
            status_next = msr_pkg::ST_MASKED;
          end else begin
            status_next   = msr_pkg::ST_SENT;
            emit_load     = 1'b1;
            emit_msg.addr = req_addr;
            emit_msg.data = msr_pkg::msg_data(data_reg[msi_i.func], mme_reg[msi_i.func], msi_i.num);
          end
        end else if (flush) begin
          emit_load     = 1'b1;
          emit_msg.addr = addr_reg[pick_func];
          emit_msg.data = msr_pkg::msg_data(data_reg[pick_func], mme_reg[pick_func], pick_num);
        end
      end
      MSR_ACK: begin
        state_next = MSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg  <= MSR_IDLE;
      status_reg <= msr_pkg::ST_SENT;
    end else begin
      state_reg  <= state_next;
      status_reg <= status_next;
    end
  end

  assign msi_ack_o    = (state_reg == MSR_ACK);
  assign msi_status_o = status_reg;

  msr_mwr_out u_out (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .load_i  (emit_load),
    .msg_i   (emit_msg),
    .ready_i (mwr_ready_i),
    .valid_o (mwr_valid_o),
    .msg_o   (mwr_o)
  );
  assign emit_busy = mwr_valid_o;

  // Configuration writes, pending updates and reads
  always_comb begin
    logic [2:0] mme_w;
    mme_w = cfg_i.wdata[msr_pkg::MME_LSB +: 3];
    for (int f = 0; f < NF; f++) begin
      en_next[f]   = en_reg[f];
      mme_next[f]  = mme_reg[f];
      addr_next[f] = addr_reg[f];
      data_next[f] = data_reg[f];
      mask_next[f] = mask_reg[f];
      pend_next[f] = pend_reg[f];
    end
    if (cfg_i.wr) begin
      unique case (cfg_i.addr)
        msr_pkg::CTRL_OFS: begin
          en_next[cfg_i.func]  = cfg_i.wdata[msr_pkg::EN_BIT];
          mme_next[cfg_i.func] = (mme_w > msr_pkg::MMC_VAL) ? msr_pkg::MMC_VAL : mme_w;
        end
        msr_pkg::ADDR_LO_OFS: addr_next[cfg_i.func][31:0]  = {cfg_i.wdata[31:2], 2'b00};
        msr_pkg::ADDR_HI_OFS: addr_next[cfg_i.func][63:32] = cfg_i.wdata;
        msr_pkg::DATA_OFS:    data_next[cfg_i.func]        = cfg_i.wdata[15:0];
        msr_pkg::MASK_OFS:    mask_next[cfg_i.func]        = cfg_i.wdata;
        msr_pkg::PEND_OFS:    pend_next[cfg_i.func]        = pend_reg[cfg_i.func] & ~cfg_i.wdata;
        default: ;
      endcase
    end
    if (flush) begin
      pend_next[pick_func][pick_num] = 1'b0;
    end
    // A new masked request wins over a clear in the same cycle
    if (take && req_en && req_vec_ok && req_masked) begin
      pend_next[msi_i.func][msi_i.num] = 1'b1;
    end
    rvalid_next = cfg_i.rd;
    rdata_next  = 32'h0000_0000;
    if (cfg_i.rd) begin
      unique case (cfg_i.addr)
        msr_pkg::CTRL_OFS: begin
          rdata_next[7:0]                        = msr_pkg::CAP_ID;
          rdata_next[msr_pkg::NEXT_LSB +: 8]     = msr_pkg::NEXT_PTR;
          rdata_next[msr_pkg::EN_BIT]            = en_reg[cfg_i.func];
          rdata_next[msr_pkg::MMC_LSB +: 3]      = msr_pkg::MMC_VAL;
          rdata_next[msr_pkg::MME_LSB +: 3]      = mme_reg[cfg_i.func];
          rdata_next[msr_pkg::A64_BIT]           = 1'b1;
          rdata_next[msr_pkg::PVM_BIT]           = 1'b1;
        end
        msr_pkg::ADDR_LO_OFS: rdata_next = addr_reg[cfg_i.func][31:0];
        msr_pkg::ADDR_HI_OFS: rdata_next = addr_reg[cfg_i.func][63:32];
        msr_pkg::DATA_OFS:    rdata_next = {16'h0000, data_reg[cfg_i.func]};
        msr_pkg::MASK_OFS:    rdata_next = mask_reg[cfg_i.func];
        msr_pkg::PEND_OFS:    rdata_next = pend_reg[cfg_i.func];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int f = 0; f < NF; f++) begin
        en_reg[f]   <= 1'b0;
        mme_reg[f]  <= msr_pkg::MME_RST;
        addr_reg[f] <= msr_pkg::ADDR_RST;
        data_reg[f] <= msr_pkg::DATA_RST;
        mask_reg[f] <= msr_pkg::MASK_RST;
        pend_reg[f] <= msr_pkg::PEND_RST;
      end
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      for (int f = 0; f < NF; f++) begin
        en_reg[f]   <= en_next[f];
        mme_reg[f]  <= mme_next[f];
        addr_reg[f] <= addr_next[f];
        data_reg[f] <= data_next[f];
        mask_reg[f] <= mask_next[f];
        pend_reg[f] <= pend_next[f];
      end
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfg_rdata_o  = rdata_reg;
  assign cfg_rvalid_o = rvalid_reg;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_ack_one_cycle: assert property (msi_ack_o |=> !msi_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_ack_follows_take: assert property (take |=> msi_ack_o)
    else $error("request taken without acknowledge next cycle");
  a_sent_has_msg: assert property (take && req_en && req_vec_ok && !req_masked
                                   |=> msi_ack_o && msi_status_o == msr_pkg::ST_SENT && mwr_valid_o)
    else $error("unmasked request not sent with code 0");
  a_sent_addr_match: assert property (take && req_en && req_vec_ok && !req_masked
                                      |=> mwr_o.addr == $past(req_addr))
    else $error("message address differs from programmed address");
  a_drop_when_off: assert property (take && !req_en
                                    |=> msi_ack_o && msi_status_o == msr_pkg::ST_DROPPED && !mwr_valid_o)
    else $error("disabled request not dropped with code 2");
  a_masked_pending: assert property (take && req_en && req_vec_ok && req_masked
                                     |=> msi_status_o == msr_pkg::ST_MASKED && !mwr_valid_o
                                         && pend_reg[$past(msi_i.func)][$past(msi_i.num)])
    else $error("masked request did not set pending with code 1");
  a_flush_clears: assert property (flush
                                   |=> mwr_valid_o && !pend_reg[$past(pick_func)][$past(pick_num)])
    else $error("unmasked pending interrupt not sent and cleared");
  a_enable_write: assert property (cfg_i.wr && cfg_i.addr == msr_pkg::CTRL_OFS
                                   |=> en_reg[$past(cfg_i.func)] == $past(cfg_i.wdata[msr_pkg::EN_BIT]))
    else $error("enable bit did not follow control write");
  a_mask_write: assert property (cfg_i.wr && cfg_i.addr == msr_pkg::MASK_OFS
                                 |=> mask_reg[$past(cfg_i.func)] == $past(cfg_i.wdata))
    else $error("mask register did not follow write");
  a_pend_read: assert property (cfg_i.rd && cfg_i.addr == msr_pkg::PEND_OFS
                                |=> cfg_rvalid_o && cfg_rdata_o == $past(pend_reg[cfg_i.func]))
    else $error("pending read returned wrong value");

  // Vector count, pending clears, read answer and message hold
  a_drop_range: assert property (take && req_en && !req_vec_ok
                                 |=> msi_ack_o && msi_status_o == msr_pkg::ST_DROPPED && !mwr_valid_o)
    else $error("request beyond enabled vector count not dropped");
  a_mme_clamp: assert property (cfg_i.wr && cfg_i.addr == msr_pkg::CTRL_OFS
                                |=> mme_reg[$past(cfg_i.func)]
                                    == (($past(cfg_i.wdata[msr_pkg::MME_LSB +: 3]) > msr_pkg::MMC_VAL)
                                        ? msr_pkg::MMC_VAL : $past(cfg_i.wdata[msr_pkg::MME_LSB +: 3])))
    else $error("vector count did not follow control write");
  a_pend_w1c: assert property (cfg_i.wr && cfg_i.addr == msr_pkg::PEND_OFS && !(take && req_masked)
                               |=> (pend_reg[$past(cfg_i.func)] & $past(cfg_i.wdata)) == 32'h0000_0000)
    else $error("written pending bits not cleared");
  a_flush_pending: assert property (flush
                                    |-> pend_reg[pick_func][pick_num] && !mask_reg[pick_func][pick_num])
    else $error("held interrupt sent without pending bit or while masked");
  a_read_answer: assert property (cfg_rvalid_o == $past(cfg_i.rd))
    else $error("read answer not one cycle after read strobe");
  a_msg_hold: assert property (mwr_valid_o && !mwr_ready_i
                               |=> mwr_valid_o && $stable(mwr_o))
    else $error("message changed before it was taken");

  c_sent:    cover property (msi_ack_o && msi_status_o == msr_pkg::ST_SENT);
  c_masked:  cover property (msi_ack_o && msi_status_o == msr_pkg::ST_MASKED);
  c_dropped: cover property (msi_ack_o && msi_status_o == msr_pkg::ST_DROPPED);
  c_flush:   cover property (flush ##1 mwr_valid_o);
  c_pend_clr: cover property (cfg_i.wr && cfg_i.addr == msr_pkg::PEND_OFS
                              && pend_reg[cfg_i.func] != 32'h0000_0000);
endmodule
`default_nettype wire

// >>> msr_app_model.sv
// Application-side requester that raises interrupts and waits for the acknowledge
`default_nettype none
module msr_app_model (
  input  wire logic                  clk_i,
  input  wire logic                  ack_i,
  input  wire logic [1:0]            status_i,
  output var  msr_pkg::msr_msi_req_t msi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial msi_o = '0;

  // Called just after a clock edge; returns just after the edge following the one where the acknowledge is seen
  task automatic raise(input logic [1:0] f, input logic [4:0] n, output logic [1:0] code);
    code = 2'bxx;
    msi_o.req  = 1'b1;
    msi_o.func = f;
    msi_o.num  = n;
    for (int k = 0; k < 60; k++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        code = status_i;
        break;
      end
    end
    #2;
    // Released qualifiers do not keep their last value
    msi_o.req  = 1'b0;
    msi_o.func = ~f;
    msi_o.num  = ~n;
    // One idle edge keeps a following request from re-raising in the same step
    @(posedge clk_i);
    #2;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the MSI request, mask and pending block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk_i = 1'b0;
  logic                  rstn_i = 1'b0;
  logic                  mwr_ready_i = 1'b0;
  msr_pkg::msr_cfg_req_t cfg_i = '0;
  msr_pkg::msr_msi_req_t msi_i;
  msr_pkg::msr_mwr_t     mwr_o;
  msr_pkg::msr_mwr_t     last_msg;
  logic [31:0]           cfg_rdata_o;
  logic                  cfg_rvalid_o;
  logic                  msi_ack_o;
  logic                  mwr_valid_o;
  logic                  ack_d;
  logic [1:0]            msi_status_o;
  logic [1:0]            code;
  logic [1:0]            f;
  logic [4:0]            n;
  logic [2:0]            em;
  logic [31:0]           r;
  logic [63:0]           msi_addr;
  logic [15:0]           msi_data;
  int                    seed = 23307;
  int                    fails = 0;
  int                    checked = 0;
  int                    msg_cnt = 0;
  int                    cyc = 0;
  int                    n0;

  always #10 clk_i = ~clk_i;

  msr_msi_ctrl uut (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .msi_i(msi_i), .msi_ack_o(msi_ack_o), .msi_status_o(msi_status_o),
    .mwr_valid_o(mwr_valid_o), .mwr_o(mwr_o), .mwr_ready_i(mwr_ready_i));

  msr_app_model app (.clk_i(clk_i), .ack_i(msi_ack_o), .status_i(msi_status_o), .msi_o(msi_i));

  // Transaction side stalls about a quarter of the time
  always @(posedge clk_i) begin
    #2;
    mwr_ready_i = ($random(seed) & 3) != 0;
  end

  task automatic end_of_test();
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  always @(posedge clk_i) begin
    if (mwr_valid_o === 1'b1 && mwr_ready_i === 1'b1) begin
      msg_cnt++;
      last_msg = mwr_o;
    end
    if (msi_ack_o === 1'b1 && ack_d === 1'b1) chk(96'h0, 96'h1, "ack longer than one cycle");
    ack_d = msi_ack_o;
    cyc++;
    if (cyc == 10000) begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [95:0] exp_msg(input logic [2:0] m, input logic [4:0] v);
    logic [15:0] sel;
    sel = (16'h0001 << m) - 16'h0001;
    return {msi_addr, 16'h0000, (msi_data & ~sel) | ({11'h000, v} & sel)};
  endfunction

  task automatic wr(input logic [1:0] fn, input logic [11:0] a, input logic [31:0] v);
    cfg_i.wr    = 1'b1;
    cfg_i.func  = fn;
    cfg_i.addr  = a;
    cfg_i.wdata = v;
    @(posedge clk_i);
    #2;
    cfg_i.wr = 1'b0;
    @(posedge clk_i);
    #2;
  endtask

  task automatic rd(input logic [1:0] fn, input logic [11:0] a, input logic [31:0] exp, input string what);
    cfg_i.rd   = 1'b1;
    cfg_i.func = fn;
    cfg_i.addr = a;
    @(posedge clk_i);
    #2;
    cfg_i.rd = 1'b0;
    chk({95'h0, cfg_rvalid_o}, 96'h1, "read answer");
    chk({64'h0, cfg_rdata_o}, {64'h0, exp}, what);
    @(posedge clk_i);
    #2;
  endtask

  task automatic wait_msg(input int c0, input logic [95:0] exp);
    for (int k = 0; k < 40 && msg_cnt == c0; k++) begin
      @(posedge clk_i);
      #2;
    end
    chk(96'(msg_cnt - c0), 96'h1, "message count");
    chk(last_msg, exp, "message");
  endtask

  task automatic no_msg(input int c0);
    repeat (10) begin
      @(posedge clk_i);
      #2;
    end
    chk(96'(msg_cnt - c0), 96'h0, "unexpected message");
  endtask

  task automatic send(input logic [1:0] fn, input logic [4:0] v, input logic [2:0] m);
    int c0;
    c0 = msg_cnt;
    app.raise(fn, v, code);
    chk(code, msr_pkg::ST_SENT, "sent code");
    wait_msg(c0, exp_msg(m, v));
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    #2;
    rstn_i = 1'b1;
    wr(2'h0, 12'h004, 32'h0000_0400);
    rd(2'h0, 12'h004, 32'h0, "unmapped read");
    rd(2'h0, msr_pkg::CTRL_OFS, 32'h018a_0005, "control reset");
    rd(2'h1, msr_pkg::MASK_OFS, 32'h0, "mask reset");
    rd(2'h1, msr_pkg::PEND_OFS, 32'h0, "pending reset");
    n0 = msg_cnt;
    app.raise(2'h0, 5'h00, code);
    chk(code, msr_pkg::ST_DROPPED, "disabled code");
    no_msg(n0);
    msi_addr = {$random(seed), $random(seed)} & ~64'h3;
    msi_data = 16'($random(seed));
    for (int i = 0; i < 4; i++) begin
      wr(2'(i), msr_pkg::ADDR_LO_OFS, msi_addr[31:0] | 32'h0000_0003);
      wr(2'(i), msr_pkg::ADDR_HI_OFS, msi_addr[63:32]);
      wr(2'(i), msr_pkg::DATA_OFS, {16'h0000, msi_data});
      rd(2'(i), msr_pkg::ADDR_LO_OFS, msi_addr[31:0], "address low");
      rd(2'(i), msr_pkg::ADDR_HI_OFS, msi_addr[63:32], "address high");
      rd(2'(i), msr_pkg::DATA_OFS, {16'h0000, msi_data}, "data");
      wr(2'(i), msr_pkg::CTRL_OFS, 32'h0051_0000);
    end
    // Every vector count, the last pass writing an oversized count
    for (int m = 0; m < 7; m++) begin
      em = (m == 6) ? 3'h5 : 3'(m);
      wr(2'h0, msr_pkg::CTRL_OFS, 32'h0001_0000 | (32'((m == 6) ? 7 : m) << 20));
      rd(2'h0, msr_pkg::CTRL_OFS, 32'h018b_0005 | (32'(em) << 20), "control");
      send(2'h0, 5'((1 << em) - 1), em);
      if (em < 5) begin
        app.raise(2'h0, 5'(1 << em), code);
        chk(code, msr_pkg::ST_DROPPED, "vector out of range");
      end
    end
    repeat (40) begin
      f = 2'($random(seed));
      n = 5'($random(seed));
      r = $random(seed);
      wr(f, msr_pkg::MASK_OFS, r);
      n0 = msg_cnt;
      app.raise(f, n, code);
      if (r[n] !== 1'b1) begin
        chk(code, msr_pkg::ST_SENT, "sent code");
        wait_msg(n0, exp_msg(3'h5, n));
      end else begin
        chk(code, msr_pkg::ST_MASKED, "masked code");
        no_msg(n0);
        rd(f, msr_pkg::PEND_OFS, 32'h1 << n, "pending set");
        if ($random(seed) & 1) begin
          wr(f, msr_pkg::PEND_OFS, 32'h1 << n);
          rd(f, msr_pkg::PEND_OFS, 32'h0, "pending cleared while masked");
          wr(f, msr_pkg::MASK_OFS, 32'h0);
          no_msg(n0);
        end else begin
          wr(f, msr_pkg::MASK_OFS, 32'h0);
          wait_msg(n0, exp_msg(3'h5, n));
        end
        rd(f, msr_pkg::PEND_OFS, 32'h0, "pending after unmask");
      end
      wr(f, msr_pkg::MASK_OFS, 32'h0);
    end
    // Reset in mid-run with a held interrupt
    wr(2'h3, msr_pkg::MASK_OFS, 32'hffff_ffff);
    app.raise(2'h3, 5'h1f, code);
    chk(code, msr_pkg::ST_MASKED, "masked code");
    rstn_i = 1'b0;
    @(posedge clk_i);
    #2;
    rstn_i = 1'b1;
    rd(2'h3, msr_pkg::PEND_OFS, 32'h0, "pending after reset");
    rd(2'h3, msr_pkg::CTRL_OFS, 32'h018a_0005, "control after reset");
    rd(2'h3, msr_pkg::MASK_OFS, 32'h0, "mask after reset");
    end_of_test();
  end
endmodule
`default_nettype wire
